/* design/boot_entry.v */
// on-board programming entry, bit rate adjust and serial program loader
`timescale 1ns/10ps
`include "boot_entry_defines.vh"
// Functional notes
// - reset-start with programming pins enters boot or user program mode only
// - fwe and pin0 high; pin2 low boot, high user; pin1 picks mode 5/7
// - boot mode copies pin1, pin0 and inverted pin2 into mode select bits
// - mode 6 blocks both programming modes; host keeps fwe low there
// - boot loads program into ram then branches to fixed start address
// - measure low period of repeated zero bytes to find host bit rate
// - frames are eight data bits, one stop, no parity
// - after rate found, send one zero byte to host
// - ram split into loader area and user area, loader area freed at run
// - receive line high at reset release; wait about 100 states before measuring
// - any non-erased flash location forces erase of all blocks
// - no interrupt service during flash program or erase
// - before branch clear rx/tx enables, keep divisor, drive transmit high
// - watchdog reset in boot keeps boot state and restarts loader
// - user program mode is mode 5/7 with fwe high, modules normal
// - flash read data invalid during program or erase
module boot_entry #(
  parameter AW = 10,
  parameter LOAD_BASE = 10'h040
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire flash_write_enable,
  input wire mode_pin_2,
  input wire mode_pin_1,
  input wire mode_pin_0,
  input wire watchdog_reset,
  input wire serial_receive_pin,
  output wire serial_transmit_pin,
  output wire serial_transmit_oe_n,
  input wire flash_busy,
  input wire flash_nonblank,
  input wire flash_erase_done,
  output wire flash_erase_req,
  output wire flash_read_valid,
  output wire irq_block,
  output wire branch_valid,
  output wire [23:0] branch_addr,
  output wire loader_area_free
);
  // loader states, one-hot
  localparam S_WAIT = 8'h01;
  localparam S_MEAS = 8'h02;
  localparam S_SEND = 8'h04;
  localparam S_ACK = 8'h08;
  localparam S_LOAD = 8'h10;
  localparam S_ERASE = 8'h20;
  localparam S_RUN = 8'h40;
  localparam S_IDLE = 8'h80;

  reg [7:0] st_q;
  reg [2:0] mode_q;
  reg fwe_q;
  reg sampled_q;
  reg boot_q;
  reg user_q;
  reg rx_en_q;
  reg tx_en_q;
  reg tx_dir_q;
  reg tx_out_q;
  reg [15:0] div_q;
  reg [15:0] wait_q;
  reg [19:0] low_q;
  reg rx_q;
  reg [15:0] len_q;
  reg [15:0] cnt_q;
  reg erase_q;
  // serial receive
  reg rx_busy_q;
  reg [15:0] rx_tick_q;
  reg [3:0] rx_bit_q;
  reg [7:0] rx_sh_q;
  reg rx_done_q;
  // serial transmit
  reg tx_busy_q;
  reg [15:0] tx_tick_q;
  reg [3:0] tx_bit_q;
  reg [9:0] tx_sh_q;
  reg tx_start_q;

  wire is_mode6 = ~mode_q[2] & mode_q[1] & ~mode_q[0]; // pin2 is held inverted
  wire is_mode5 = mode_q[0] & ~mode_q[1];
  wire is_mode7 = mode_q[0] & mode_q[1];
  wire [15:0] half_div = {1'b0, div_q[15:1]};
  wire [19:0] low_ninth = low_q / {15'h0000, `ZERO_FRAME_BITS}; // one bit time
  wire setup = psel & ~penable;
  wire access = psel & penable;
  wire wr = access & pwrite;
  wire ram_we = (st_q == S_LOAD) & rx_done_q;
  wire [AW-1:0] ram_waddr = LOAD_BASE + cnt_q[AW-1:0];
  wire [7:0] ram_rdata;
  reg [AW-1:0] ram_raddr_q;

  // zero-wait slave; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = access & (paddr > `REG_RAM_WINDOW + 12'h004 || paddr[1:0] != 2'b00);

  // mode pins taken once at reset release; a watchdog reset leaves them alone
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sampled_q <= 1'b0;
      mode_q <= 3'b000;
      fwe_q <= 1'b0;
      boot_q <= 1'b0;
      user_q <= 1'b0;
    end else if (!sampled_q) begin
      sampled_q <= 1'b1;
      mode_q <= {~mode_pin_2, mode_pin_1, mode_pin_0}; // pin2 is inverted in boot
      fwe_q <= flash_write_enable;
      // mode 6 never reaches programming modes
      boot_q <= flash_write_enable & mode_pin_0 & ~mode_pin_2;
      user_q <= flash_write_enable & mode_pin_0 & mode_pin_2;
    end
  end

  // receive line registered before use
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_q <= 1'b1;
    end else begin
      rx_q <= serial_receive_pin;
    end
  end

  // loader sequence
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= S_WAIT;
      wait_q <= 16'h0000;
      low_q <= 20'h00000;
      div_q <= 16'h0000;
      rx_en_q <= 1'b0;
      tx_en_q <= 1'b0;
      tx_dir_q <= 1'b0;
      tx_out_q <= 1'b1;
      len_q <= `LOAD_LEN_RESET;
      cnt_q <= 16'h0000;
      erase_q <= 1'b0;
      tx_start_q <= 1'b0;
    end else begin
      tx_start_q <= 1'b0;
      if (wr && paddr == `REG_LOAD_CTRL) begin
        len_q <= pwdata[15:0];
      end
      if (wr && paddr == `REG_SERIAL_CTRL && st_q == S_RUN) begin
        rx_en_q <= pwdata[`SC_RX_EN];
        tx_en_q <= pwdata[`SC_TX_EN];
      end
      if (wr && paddr == `REG_BAUD_DIV && st_q == S_RUN) begin
        div_q <= pwdata[15:0];
      end
      if (watchdog_reset && boot_q) begin
        st_q <= S_WAIT; // loader restarts, boot kept
        wait_q <= 16'h0000;
        cnt_q <= 16'h0000;
      end else begin
        case (st_q)
          S_WAIT: begin
            // roughly 100 states before measuring
            if (!sampled_q || !boot_q) begin
              if (sampled_q) begin
                st_q <= S_IDLE;
              end
            end else if (wait_q < `READY_STATES) begin
              wait_q <= wait_q + 16'h0001;
            end else if (rx_q) begin
              st_q <= S_MEAS;
              low_q <= 20'h00000;
            end
          end
          S_MEAS: begin
            // low of a zero byte spans start plus eight bits
            if (!rx_q) begin
              low_q <= low_q + 20'h00001;
            end else if (low_q != 20'h00000) begin
              div_q <= low_ninth[15:0];
              rx_en_q <= 1'b1;
              tx_en_q <= 1'b1;
              tx_dir_q <= 1'b1;
              st_q <= S_SEND;
              tx_start_q <= 1'b1; // one zero byte ends adjustment
            end
          end
          S_SEND: begin
            if (!tx_busy_q && !tx_start_q) begin
              st_q <= S_ACK;
            end
          end
          S_ACK: begin
            // wait for acknowledge byte; others ignored
            if (rx_done_q && rx_sh_q == `ACK_BYTE) begin
              st_q <= flash_nonblank ? S_ERASE : S_LOAD;
              erase_q <= flash_nonblank;
            end
          end
          S_ERASE: begin
            if (flash_erase_done) begin
              erase_q <= 1'b0;
              st_q <= S_LOAD;
            end
          end
          S_LOAD: begin
            // stream into user ram area
            if (rx_done_q) begin
              cnt_q <= cnt_q + 16'h0001;
              if (cnt_q + 16'h0001 >= len_q) begin
                st_q <= S_RUN;
                rx_en_q <= 1'b0;
                tx_en_q <= 1'b0;
                tx_out_q <= 1'b1; // transmit high as output
              end
            end
          end
          S_RUN: begin
            st_q <= S_RUN;
          end
          S_IDLE: begin
            st_q <= S_IDLE;
          end
          default: begin
            st_q <= S_IDLE;
          end
        endcase
      end
    end
  end

  // receiver: 8 data, 1 stop, no parity
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_busy_q <= 1'b0;
      rx_tick_q <= 16'h0000;
      rx_bit_q <= 4'h0;
      rx_sh_q <= 8'h00;
      rx_done_q <= 1'b0;
    end else begin
      rx_done_q <= 1'b0;
      if (!rx_en_q) begin
        rx_busy_q <= 1'b0;
      end else if (!rx_busy_q) begin
        if (!rx_q) begin
          rx_busy_q <= 1'b1;
          rx_tick_q <= half_div;
          rx_bit_q <= 4'h0;
        end
      end else if (rx_tick_q != 16'h0000) begin
        rx_tick_q <= rx_tick_q - 16'h0001;
      end else begin
        rx_tick_q <= div_q;
        rx_bit_q <= rx_bit_q + 4'h1;
        if (rx_bit_q >= 4'h1 && rx_bit_q <= 4'h8) begin
          rx_sh_q <= {rx_q, rx_sh_q[7:1]};
        end
        if (rx_bit_q == 4'h9) begin
          rx_busy_q <= 1'b0;
          rx_done_q <= rx_q; // framing error drops byte
        end
      end
    end
  end

  // transmitter, lsb first, idles high
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_busy_q <= 1'b0;
      tx_tick_q <= 16'h0000;
      tx_bit_q <= 4'h0;
      tx_sh_q <= 10'h3ff;
    end else if (tx_start_q) begin
      tx_busy_q <= 1'b1;
      tx_tick_q <= div_q;
      tx_bit_q <= 4'h0;
      tx_sh_q <= {1'b1, `SYNC_BYTE, 1'b0};
    end else if (tx_busy_q) begin
      if (tx_tick_q != 16'h0000) begin
        tx_tick_q <= tx_tick_q - 16'h0001;
      end else begin
        tx_tick_q <= div_q;
        tx_sh_q <= {1'b1, tx_sh_q[9:1]};
        tx_bit_q <= tx_bit_q + 4'h1;
        if (tx_bit_q == 4'h9) begin
          tx_busy_q <= 1'b0;
        end
      end
    end
  end

  // ram readback pointer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ram_raddr_q <= {AW{1'b0}};
    end else if (wr && paddr == `REG_RAM_WINDOW) begin
      ram_raddr_q <= pwdata[AW-1:0];
    end
  end

  loader_ram #(.AW(AW)) u_ram (
    .pclk(pclk),
    .we(ram_we),
    .waddr(ram_waddr),
    .wdata(rx_sh_q),
    .raddr(ram_raddr_q),
    .rdata(ram_rdata)
  );

  // read mux registered on the setup cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (setup && !pwrite) begin
      case (paddr)
        `REG_MODE_STATUS: prdata <= {21'h000000, is_mode7, is_mode5, fwe_q, st_q == S_RUN,
                                     st_q == S_LOAD || st_q == S_RUN, is_mode6, user_q, boot_q,
                                     boot_q ? mode_q : 3'b000};
        `REG_SERIAL_CTRL: prdata <= {28'h0000000, tx_out_q, tx_dir_q, tx_en_q, rx_en_q};
        `REG_BAUD_DIV: prdata <= {16'h0000, div_q};
        `REG_LOAD_CTRL: prdata <= {16'h0000, len_q};
        `REG_LOAD_COUNT: prdata <= {16'h0000, cnt_q};
        `REG_BRANCH_ADDR: prdata <= {8'h00, `BRANCH_START};
        `REG_RAM_WINDOW: prdata <= {24'h000000, ram_rdata};
        `REG_FLASH_CTRL: prdata <= {28'h0000000, flash_erase_done, erase_q, flash_nonblank, flash_busy};
        default: prdata <= 32'h00000000;
      endcase
    end
  end

  // transmit pin: data while busy, otherwise held high
  assign serial_transmit_pin = tx_busy_q ? tx_sh_q[0] : tx_out_q;
  assign serial_transmit_oe_n = ~(tx_dir_q & (tx_en_q | st_q == S_RUN));
  assign flash_erase_req = erase_q;
  assign flash_read_valid = ~flash_busy;
  assign irq_block = flash_busy | erase_q;
  assign branch_valid = st_q == S_RUN;
  assign branch_addr = `BRANCH_START;
  assign loader_area_free = st_q == S_RUN;
endmodule // boot_entry

/* design/boot_entry_defines.vh */
// constants for the on-board programming entry and serial loader block
`ifndef BOOT_ENTRY_DEFINES_VH
`define BOOT_ENTRY_DEFINES_VH
// apb register byte offsets
`define REG_MODE_STATUS 12'h000
`define REG_SERIAL_CTRL 12'h004
`define REG_BAUD_DIV 12'h008
`define REG_LOAD_CTRL 12'h00c
`define REG_LOAD_COUNT 12'h010
`define REG_BRANCH_ADDR 12'h014
`define REG_RAM_WINDOW 12'h018
`define REG_FLASH_CTRL 12'h01c
// mode status field positions
`define MS_MODE_LO 0
`define MS_BOOT 3
`define MS_USER 4
`define MS_MODE6 5
`define MS_LOADED 6
`define MS_RUN 7
`define MS_FWE 8
`define MS_MODE5 9
`define MS_MODE7 10
// serial control field positions
`define SC_RX_EN 0
`define SC_TX_EN 1
`define SC_TX_DIR 2
`define SC_TX_OUT 3
// flash control field positions
`define FC_BUSY 0
`define FC_NONBLANK 1
`define FC_ERASE_REQ 2
`define FC_ERASE_DONE 3
// loader constants
`define BRANCH_START 24'hffe720
`define SYNC_BYTE 8'h00
`define ACK_BYTE 8'h55
`define READY_STATES 16'd100
`define ZERO_FRAME_BITS 5'd9
`define LOAD_LEN_RESET 16'h0100
`endif

/* design/loader_ram.v */
// loader ram: one write port, registered read port
`timescale 1ns/10ps
module loader_ram #(
  parameter AW = 10
) (
  input wire pclk,
  input wire we,
  input wire [AW-1:0] waddr,
  input wire [7:0] wdata,
  input wire [AW-1:0] raddr,
  output reg [7:0] rdata
);
  reg [7:0] mem [0:(1<<AW)-1];
  // no reset on storage; read data from a register
  always @(posedge pclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule // loader_ram

/* testbench/boot_entry_props.sv */
// concurrent checks on the boot entry block outputs
`timescale 1ns/10ps
module boot_entry_props (
  input wire pclk,
  input wire presetn,
  input wire watchdog_reset,
  input wire serial_transmit_pin,
  input wire serial_transmit_oe_n,
  input wire flash_busy,
  input wire flash_erase_done,
  input wire flash_erase_req,
  input wire flash_read_valid,
  input wire irq_block,
  input wire branch_valid,
  input wire [23:0] branch_addr,
  input wire loader_area_free
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  chk_branch_target: assert property (branch_valid |-> branch_addr == 24'hffe720)
    else $error("branch target wrong");
  chk_branch_hold: assert property (branch_valid && !watchdog_reset |=> branch_valid)
    else $error("branch state lost");
  chk_tx_parked: assert property (branch_valid |-> serial_transmit_pin && !serial_transmit_oe_n)
    else $error("transmit pin not driven high");
  chk_area_freed: assert property ($rose(branch_valid) |-> loader_area_free)
    else $error("loader area not freed");
  chk_read_blocked: assert property (flash_busy |-> !flash_read_valid)
    else $error("flash read valid while busy");
  chk_irq_masked: assert property (flash_busy |-> irq_block)
    else $error("interrupts open while busy");
  chk_erase_waits: assert property (flash_erase_req && !flash_erase_done |=> flash_erase_req)
    else $error("erase request dropped early");
  chk_wdog_restart: assert property (branch_valid && watchdog_reset |-> ##[1:4] !branch_valid)
    else $error("loader not restarted");
  chk_quiet_start: assert property ($rose(presetn) |-> (serial_transmit_oe_n || serial_transmit_pin) [*8])
    else $error("transmit line low after reset");
  cover property ($rose(branch_valid));
  cover property ($rose(flash_erase_req));
  cover property (branch_valid && watchdog_reset);
endmodule // boot_entry_props

/* testbench/host_serial.sv */
// host side of the boot serial link
`timescale 1ns/10ps
module host_serial #(
  parameter BIT_NS = 463
) (
  input wire go,
  input wire send_prog,
  input wire txd,
  output reg rxd,
  output reg [7:0] got
);
  integer i;
  integer k;
  reg done;
  // one frame: start, eight bits lsb first, one stop, no parity
  task send_byte(input [7:0] b);
    begin
      rxd = 1'b0;
      #(BIT_NS);
      for (i = 0; i < 8; i = i + 1) begin
        rxd = b[i];
        #(BIT_NS);
      end
      rxd = 1'b1;
      #(BIT_NS);
    end
  endtask
  // receiver beside the sender, the reply can start mid stop bit
  initial begin
    got = 8'hff;
    done = 1'b0;
    wait (go);
    @(negedge txd);
    #(BIT_NS * 3 / 2);
    repeat (8) begin
      got = {txd, got[7:1]};
      #(BIT_NS);
    end
    done = 1'b1;
  end
  // line idles high; scaled rate stands in for a permitted one
  initial begin
    rxd = 1'b1;
    k = 0;
    wait (go);
    #0.3; // step off the clock edge so the device never races the line
    // gap after each zero so the reply never overlaps a new frame
    while (!done && k < 8) begin
      send_byte(8'h00);
      #(12 * BIT_NS);
      k = k + 1;
    end
    if (got == 8'h00) begin
      send_byte(8'h55);
    end
    wait (send_prog);
    #0.3;
    for (k = 0; k < 4; k = k + 1) begin
      send_byte(8'h3c ^ k[7:0]);
    end
  end
endmodule // host_serial

/* testbench/onboard_flash_boot_entry_bench.sv */
// self-checking bench for the boot entry block
`timescale 1ns/10ps
`include "boot_entry_defines.vh"
module onboard_flash_boot_entry_bench;
  localparam integer BIT_NS = 463; // host bit time scaled down along with the clock
  localparam [31:0] LOAD_AT = 32'h00000040; // base of the user load area, design default
  localparam integer DIV = (9 * BIT_NS / 25) / 9;
  localparam [19:0] MODES = {4'b1101, 4'b1111, 4'b0110, 4'b1011, 4'b1001};
  reg pclk = 1'b0;
  reg presetn = 1'b0;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0;
  reg [3:0] pins = 4'b1001;
  reg wdr = 1'b0;
  reg busy = 1'b0;
  reg nonblank = 1'b0;
  reg edone = 1'b0;
  reg go = 1'b0;
  reg send_prog = 1'b0;
  reg [31:0] rd;
  reg err;
  integer mismatches = 0;
  integer n_checks = 0;
  integer i;
  wire [31:0] prdata;
  wire pready, pslverr, txp, oe_n, ereq, rvalid, irqb, bvalid, free, rxd;
  wire [23:0] baddr;
  wire [7:0] got;
  // transmit line is pulled up when released
  wire txd = oe_n ? 1'b1 : txp;
  always #12.5 pclk = ~pclk;
  boot_entry dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .flash_write_enable(pins[3]), .mode_pin_2(pins[2]),
    .mode_pin_1(pins[1]), .mode_pin_0(pins[0]), .watchdog_reset(wdr),
    .serial_receive_pin(rxd), .serial_transmit_pin(txp), .serial_transmit_oe_n(oe_n),
    .flash_busy(busy), .flash_nonblank(nonblank), .flash_erase_done(edone),
    .flash_erase_req(ereq), .flash_read_valid(rvalid), .irq_block(irqb),
    .branch_valid(bvalid), .branch_addr(baddr), .loader_area_free(free));
  host_serial #(.BIT_NS(BIT_NS)) host (.go(go), .send_prog(send_prog), .txd(txd), .rxd(rxd), .got(got));
  task chk(input [31:0] seen, input [31:0] exp, input [63:0] what);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("[FAIL] %0s exp %h seen %h", what, exp, seen);
      end
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask
  task rst(input [3:0] p, input integer n);
    begin
      presetn <= 1'b0;
      pins <= p;
      repeat (n) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
    end
  endtask
  // status bits 10..3 expected from {fwe, pin2, pin1, pin0}
  function [31:0] exp_st(input [3:0] p);
    begin
      exp_st = {21'h0, p[0] & p[1], p[0] & ~p[1], p[3], 2'b00, p[2] & p[1] & ~p[0],
        p[3] & p[0] & p[2], p[3] & p[0] & ~p[2], 3'b000};
    end
  endfunction
  task summarize;
    begin
      if (mismatches == 0 && n_checks > 0) begin
        $display("bench passed");
      end else begin
        $display("bench failed");
      end
      $finish;
    end
  endtask
  // mode table, then a full boot load, then a watchdog restart
  initial begin
    for (i = 0; i < 5; i = i + 1) begin
      rst(MODES[19 - 4 * i -: 4], (i == 0) ? 5 : 20);
      apb(1'b0, `REG_MODE_STATUS, 32'h0);
      chk(rd & 32'h7f8, exp_st(pins), "status");
      if (pins[3] & pins[0] & ~pins[2]) begin
        chk({29'h0, rd[2:0]}, {29'h0, ~pins[2], pins[1:0]}, "modesel");
      end
    end
    // pins stay as the last reset left them from here on
    apb(1'b1, `REG_LOAD_CTRL, 32'h4);
    apb(1'b0, 12'h020, 32'h0);
    chk(rd, 32'h0, "unmapped");
    chk({31'h0, err}, 32'h1, "slverr");
    nonblank <= 1'b1;
    repeat (100) @(posedge pclk);
    go <= 1'b1;
    while (ereq !== 1'b1) @(posedge pclk);
    chk({24'h0, got}, 32'h0, "adjend");
    busy <= 1'b1;
    @(posedge pclk);
    @(posedge pclk);
    chk({30'h0, irqb, rvalid}, 32'h2, "flashbsy");
    apb(1'b0, `REG_FLASH_CTRL, 32'h0);
    chk(rd, 32'h7, "flashst");
    repeat (20) @(posedge pclk);
    busy <= 1'b0;
    edone <= 1'b1;
    nonblank <= 1'b0;
    while (ereq === 1'b1) @(posedge pclk);
    edone <= 1'b0;
    send_prog <= 1'b1;
    while (bvalid !== 1'b1) @(posedge pclk);
    chk({8'h0, baddr}, 32'hffe720, "branch");
    chk({29'h0, free, txd, oe_n}, 32'h6, "parked");
    apb(1'b0, `REG_SERIAL_CTRL, 32'h0);
    chk(rd & 32'h3, 32'h0, "sctrl");
    apb(1'b0, `REG_BAUD_DIV, 32'h0);
    chk(rd, DIV, "divisor");
    apb(1'b0, `REG_LOAD_COUNT, 32'h0);
    chk(rd, 32'h4, "count");
    // loaded bytes read back through the ram window
    apb(1'b1, `REG_RAM_WINDOW, LOAD_AT);
    apb(1'b0, `REG_RAM_WINDOW, 32'h0);
    chk(rd, 32'h3c, "ram0");
    apb(1'b1, `REG_RAM_WINDOW, LOAD_AT + 32'h3);
    apb(1'b0, `REG_RAM_WINDOW, 32'h0);
    chk(rd, 32'h3f, "ram3");
    wdr <= 1'b1;
    @(posedge pclk);
    wdr <= 1'b0;
    while (bvalid === 1'b1) @(posedge pclk);
    apb(1'b0, `REG_MODE_STATUS, 32'h0);
    chk(rd & 32'h88, 32'h8, "wdboot");
    summarize;
  end
  // hang guard, far beyond the expected run time
  initial begin
    #500000;
    mismatches = mismatches + 1;
    summarize;
  end
endmodule // onboard_flash_boot_entry_bench
bind boot_entry boot_entry_props chk_i (.pclk(pclk), .presetn(presetn), .watchdog_reset(watchdog_reset),
  .serial_transmit_pin(serial_transmit_pin), .serial_transmit_oe_n(serial_transmit_oe_n),
  .flash_busy(flash_busy), .flash_erase_done(flash_erase_done), .flash_erase_req(flash_erase_req),
  .flash_read_valid(flash_read_valid), .irq_block(irq_block), .branch_valid(branch_valid),
  .branch_addr(branch_addr), .loader_area_free(loader_area_free));
